// [rtl/brsu_pkg.sv]
// shared constants for the bcd and real subtract unit and its operand fetch end
package brsu_pkg;
   // ------------------------------------------------------------
   // data widths
   // ------------------------------------------------------------
   localparam int ACC_W = 32;
   localparam int HALF_W = 16;
   localparam int DIG_W = 4;
   localparam int NDIG = 8;
   localparam int SHORT_DIG = 3;
   localparam logic [DIG_W-1:0] BCD_MAX = 4'h9;
   localparam logic [DIG_W:0] BCD_TEN = 5'h0a;
   // ------------------------------------------------------------
   // ieee single layout and datapath sizes
   // ------------------------------------------------------------
   localparam int EXP_W = 8;
   localparam int FRAC_W = 23;
   localparam int MANT_W = 24;
   localparam int GRS_W = 3;
   localparam int WIDE_W = 28;
   localparam int NORM_POS = 26;
   localparam int SIGN_POS = 31;
   localparam logic [EXP_W-1:0] EXP_MAX = 8'hff;
   // ------------------------------------------------------------
   // status flag positions
   // ------------------------------------------------------------
   localparam int FLAG_W = 9;
   localparam int F_ZERO = 0;
   localparam int F_SBOR = 1;
   localparam int F_LBOR = 2;
   localparam int F_NEG = 3;
   localparam int F_BPTR = 4;
   localparam int F_INVF = 5;
   localparam int F_SERR = 6;
   localparam int F_UNDF = 7;
   localparam int F_TYPE = 8;
   // ------------------------------------------------------------
   // operations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_LOAD = 2'b00,
      OP_DSUB = 2'b01,
      OP_RSUB = 2'b10
   } brsu_op_t;
   // ------------------------------------------------------------
   // fetch end registers
   // ------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] REG_CMD = 8'h00;
   localparam logic [REG_AW-1:0] REG_IMM = 8'h04;
   localparam logic [REG_AW-1:0] REG_MADDR = 8'h08;
   localparam logic [REG_AW-1:0] REG_MDATA = 8'h0c;
   localparam logic [REG_AW-1:0] REG_ACC = 8'h10;
   localparam logic [REG_AW-1:0] REG_FLAGS = 8'h14;
   localparam logic [REG_AW-1:0] REG_STAT = 8'h18;
   localparam logic [REG_AW-1:0] REG_IRQ_ST = 8'h1c;
   localparam logic [REG_AW-1:0] REG_IRQ_CLR = 8'h20;
   localparam logic [REG_AW-1:0] REG_IRQ_EN = 8'h24;
   localparam int CMD_IMM = 2;
   localparam int CMD_IND = 3;
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
endpackage : brsu_pkg

// [rtl/brsu_if.sv]
// link between the operand fetch end and the subtract unit
`timescale 1ns/10ps
interface brsu_if
   import brsu_pkg::*;
();
   logic req;
   brsu_op_t op;
   logic [HALF_W-1:0] lo;
   logic [HALF_W-1:0] hi;
   logic ptr_bad;
   logic ack;
   logic [ACC_W-1:0] acc;
   logic [FLAG_W-1:0] flags;
   modport unit (
      input req, op, lo, hi, ptr_bad,
      output ack, acc, flags
   );
   modport fetch (
      output req, op, lo, hi, ptr_bad,
      input ack, acc, flags
   );
endinterface : brsu_if

// [rtl/brsu_fetch.sv]
// operand fetch end: command registers, word memory, interrupt logic
`timescale 1ns/10ps
module brsu_fetch
   import brsu_pkg::*;
#(
   parameter int MEM_DEPTH = 256
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic WR,
   input wire logic RD,
   input wire logic [REG_AW-1:0] ADDR,
   input wire logic [ACC_W-1:0] WDATA,
   output logic [ACC_W-1:0] RDATA,
   output logic IRQ,
   brsu_if.fetch LINK
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT = 2'b10
   } brsu_fst_t;
   localparam int MA_W = $clog2(MEM_DEPTH);

   logic [HALF_W-1:0] mem [MEM_DEPTH];
   brsu_fst_t state_reg;
   logic [ACC_W-1:0] imm_reg;
   logic [MA_W-1:0] maddr_reg;
   logic [IRQ_W-1:0] irq_st_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [MA_W-1:0] base;
   logic [HALF_W-1:0] ptr;
   logic bad;
   logic go;
   logic [IRQ_W-1:0] ev;

   // ------------------------------------------------------------
   // operand address and pointer check
   // ------------------------------------------------------------
   assign ptr = mem[maddr_reg];
   // two words are needed, so the last word is no valid target
   assign bad = WDATA[CMD_IND] && (ptr > HALF_W'(MEM_DEPTH - 2));
   assign base = WDATA[CMD_IND] ? ptr[MA_W-1:0] : maddr_reg;
   assign go = CE && WR && (ADDR == REG_CMD) && (state_reg == ST_IDLE) && (WDATA[1:0] != 2'b11);

   // ------------------------------------------------------------
   // command sequence
   // ------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= ST_IDLE;
      end else if (CE) begin
         unique case (state_reg)
            ST_IDLE: if (go) state_reg <= ST_ISSUE;
            ST_ISSUE: state_reg <= ST_WAIT;
            ST_WAIT: if (LINK.ack) state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   assign LINK.req = (state_reg == ST_ISSUE);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LINK.op <= OP_LOAD;
         LINK.lo <= '0;
         LINK.hi <= '0;
         LINK.ptr_bad <= 1'b0;
      end else if (go) begin
         LINK.op <= brsu_op_t'(WDATA[1:0]);
         LINK.ptr_bad <= bad;
         if (WDATA[CMD_IMM]) begin
            LINK.lo <= imm_reg[HALF_W-1:0];
            LINK.hi <= imm_reg[ACC_W-1:HALF_W];
         end else begin
            LINK.lo <= mem[base];
            LINK.hi <= mem[MA_W'(base + 1'b1)];
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         imm_reg <= '0;
         maddr_reg <= '0;
         irq_en_reg <= '0;
      end else if (CE && WR) begin
         if (ADDR == REG_IMM) imm_reg <= WDATA;
         if (ADDR == REG_MADDR) maddr_reg <= WDATA[MA_W-1:0];
         if (ADDR == REG_IRQ_EN) irq_en_reg <= WDATA[IRQ_W-1:0];
      end
   end

   // memory has no reset; contents are software's business
   always_ff @(posedge CLK) begin
      if (CE && WR && ADDR == REG_MDATA) begin
         mem[maddr_reg] <= WDATA[HALF_W-1:0];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RDATA <= '0;
      end else if (CE) begin
         RDATA <= '0;
         if (RD) begin
            unique case (ADDR)
               REG_IMM: RDATA <= imm_reg;
               REG_MADDR: RDATA <= ACC_W'(maddr_reg);
               REG_MDATA: RDATA <= ACC_W'(mem[maddr_reg]);
               REG_ACC: RDATA <= LINK.acc;
               REG_FLAGS: RDATA <= ACC_W'(LINK.flags);
               REG_STAT: RDATA <= ACC_W'(state_reg != ST_IDLE);
               REG_IRQ_ST: RDATA <= ACC_W'(irq_st_reg);
               REG_IRQ_EN: RDATA <= ACC_W'(irq_en_reg);
               default: RDATA <= '0;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt status; a new event beats a clear in the same cycle
   // ------------------------------------------------------------
   assign ev[IRQ_DONE] = LINK.ack;
   assign ev[IRQ_ERR] = LINK.ack && (LINK.flags[F_TYPE] || LINK.flags[F_BPTR] || LINK.flags[F_INVF]);
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_st_reg <= '0;
      end else if (CE) begin
         irq_st_reg <= (irq_st_reg & ~((WR && ADDR == REG_IRQ_CLR) ? WDATA[IRQ_W-1:0] : '0)) | ev;
      end
   end
   assign IRQ = |(irq_st_reg & irq_en_reg);
endmodule : brsu_fetch

// [rtl/brsu_unit.sv]
// accumulator subtract unit: packed bcd and ieee single subtraction with status flags
//
// Overview of operation
// - decimal subtract: acc minus 32-bit bcd operand
// - fetch gives bcd operand, memory or constant
// - zero flag follows the new accumulator
// - short borrow out of digit three
// - long borrow out of digit seven
// - negative flag when result is negative
// - type error on any non-bcd nibble
// - flags hold until next op driving them
// - real subtract: acc minus 32-bit float
// - fetch gives real operand, memory or constant
// - real result written back to accumulator
// - both real operands in ieee single format
// - invalid float flag for nan accumulator
// - sign error flag on signed overflow
// - underflow flag on float underflow
// - type error on non-real operand
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module brsu_unit
   import brsu_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   brsu_if.unit LINK,
   output logic [ACC_W-1:0] ACC,
   output logic [FLAG_W-1:0] FLAGS,
   output logic DONE
);
   logic [ACC_W-1:0] acc_reg;
   logic [FLAG_W-1:0] flags_reg;
   logic done_reg;
   logic [ACC_W-1:0] opnd;
   logic take;
   // decimal path
   logic [ACC_W-1:0] dres;
   logic [DIG_W:0] dtmp;
   logic dbor;
   logic dsbor;
   logic dbad;
   // real path
   logic [EXP_W-1:0] ea;
   logic [EXP_W-1:0] eb;
   logic [MANT_W-1:0] ma;
   logic [MANT_W-1:0] mb;
   logic sa;
   logic sb;
   logic a_big;
   logic sl;
   logic [EXP_W-1:0] el;
   logic [EXP_W-1:0] es;
   logic [MANT_W-1:0] ml;
   logic [MANT_W-1:0] ms;
   logic [EXP_W-1:0] diff;
   logic [WIDE_W-1:0] mlx;
   logic [WIDE_W-1:0] msx;
   logic [WIDE_W-1:0] sum;
   logic [WIDE_W-1:0] norm;
   logic [4:0] lead;
   logic rnd;
   logic [MANT_W:0] mant;
   logic signed [9:0] rexp;
   logic a_nan;
   logic a_inf;
   logic b_nan;
   logic b_inf;
   logic r_ovf;
   logic r_unf;
   logic r_zero;
   logic [ACC_W-1:0] rres;

   assign opnd = {LINK.hi, LINK.lo};
   assign take = CE && LINK.req;

   // ------------------------------------------------------------
   // packed bcd subtraction, digit by digit with borrow
   // ------------------------------------------------------------
   always_comb begin
      dbor = 1'b0;
      dsbor = 1'b0;
      dbad = 1'b0;
      dtmp = '0;
      dres = '0;
      for (int i = 0; i < NDIG; i++) begin
         if (acc_reg[i*DIG_W +: DIG_W] > BCD_MAX || opnd[i*DIG_W +: DIG_W] > BCD_MAX) begin
            dbad = 1'b1;
         end
         dtmp = {1'b0, acc_reg[i*DIG_W +: DIG_W]} - {1'b0, opnd[i*DIG_W +: DIG_W]} - {4'h0, dbor};
         dbor = dtmp[DIG_W];
         dres[i*DIG_W +: DIG_W] = dbor ? DIG_W'(dtmp + BCD_TEN) : dtmp[DIG_W-1:0];
         if (i == SHORT_DIG) begin
            dsbor = dbor;
         end
      end
   end

   // ------------------------------------------------------------
   // ieee single subtraction, denormals flushed to zero
   // ------------------------------------------------------------
   always_comb begin
      ea = acc_reg[SIGN_POS-1:FRAC_W];
      eb = opnd[SIGN_POS-1:FRAC_W];
      sa = acc_reg[SIGN_POS];
      sb = ~opnd[SIGN_POS]; // subtract is add of the negated operand
      ma = (ea == '0) ? '0 : {1'b1, acc_reg[FRAC_W-1:0]};
      mb = (eb == '0) ? '0 : {1'b1, opnd[FRAC_W-1:0]};
      a_nan = (ea == EXP_MAX) && (acc_reg[FRAC_W-1:0] != '0);
      a_inf = (ea == EXP_MAX) && (acc_reg[FRAC_W-1:0] == '0);
      b_nan = (eb == EXP_MAX) && (opnd[FRAC_W-1:0] != '0);
      b_inf = (eb == EXP_MAX) && (opnd[FRAC_W-1:0] == '0);
      a_big = {ea, ma} >= {eb, mb};
      sl = a_big ? sa : sb;
      el = a_big ? ea : eb;
      es = a_big ? eb : ea;
      ml = a_big ? ma : mb;
      ms = a_big ? mb : ma;
      diff = el - es;
      mlx = {1'b0, ml, {GRS_W{1'b0}}};
      if (diff >= EXP_W'(WIDE_W)) begin
         msx = {{(WIDE_W-1){1'b0}}, ms != '0};
      end else begin
         msx = {1'b0, ms, {GRS_W{1'b0}}} >> diff;
         // bits shifted out fold into the sticky bit so rounding stays exact
         msx[0] = msx[0] | (({1'b0, ms, {GRS_W{1'b0}}} << (EXP_W'(WIDE_W) - diff)) != '0);
      end
      sum = (sa == sb) ? mlx + msx : mlx - msx;
      lead = '0;
      for (int i = 0; i < WIDE_W; i++) begin
         if (sum[i]) begin
            lead = 5'(i);
         end
      end
      if (lead == 5'(NORM_POS + 1)) begin
         norm = {1'b0, sum[WIDE_W-1:2], sum[1] | sum[0]};
      end else begin
         norm = sum << (5'(NORM_POS) - lead);
      end
      rexp = 10'(el) + 10'(lead) - 10'(NORM_POS);
      rnd = norm[2] && (norm[1] || norm[0] || norm[GRS_W]);
      mant = {1'b0, norm[NORM_POS:GRS_W]} + {{MANT_W{1'b0}}, rnd};
      if (mant[MANT_W]) begin
         mant = mant >> 1;
         rexp = rexp + 10'sd1;
      end
      r_zero = (sum == '0);
      r_ovf = !r_zero && (rexp >= $signed({2'b00, EXP_MAX}));
      r_unf = !r_zero && (rexp <= 10'sd0);
      if (r_zero || r_unf) begin
         rres = {r_unf && sl, {(ACC_W-1){1'b0}}};
      end else if (r_ovf) begin
         rres = {sl, EXP_MAX, {FRAC_W{1'b0}}};
      end else begin
         rres = {sl, rexp[EXP_W-1:0], mant[FRAC_W-1:0]};
      end
   end

   // ------------------------------------------------------------
   // accumulator; refused operands leave it untouched
   // ------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         acc_reg <= '0;
      end else if (take && !(LINK.ptr_bad && LINK.op != OP_LOAD)) begin
         unique case (LINK.op)
            OP_LOAD: acc_reg <= opnd;
            OP_DSUB: if (!dbad) acc_reg <= dres;
            OP_RSUB: if (!(a_nan || a_inf || b_nan || b_inf)) acc_reg <= rres;
            default: acc_reg <= acc_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // status flags; each op drives only its own set, others hold
   // ------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         flags_reg <= '0;
      end else if (take && LINK.op != OP_LOAD) begin
         flags_reg[F_BPTR] <= LINK.ptr_bad;
         if (LINK.ptr_bad) begin
            flags_reg[F_TYPE] <= flags_reg[F_TYPE];
         end else if (LINK.op == OP_DSUB) begin
            flags_reg[F_TYPE] <= dbad;
            if (!dbad) begin
               flags_reg[F_ZERO] <= (dres == '0);
               flags_reg[F_SBOR] <= dsbor;
               flags_reg[F_LBOR] <= dbor;
               flags_reg[F_NEG] <= dbor; // ten's complement left on borrow
            end
         end else if (LINK.op == OP_RSUB) begin
            flags_reg[F_TYPE] <= a_nan || b_nan || b_inf;
            flags_reg[F_INVF] <= a_nan || a_inf || (!b_nan && r_ovf);
            if (!(a_nan || a_inf || b_nan || b_inf)) begin
               flags_reg[F_ZERO] <= (rres[SIGN_POS-1:0] == '0);
               flags_reg[F_NEG] <= rres[SIGN_POS] && (rres[SIGN_POS-1:0] != '0);
               flags_reg[F_SERR] <= r_ovf; // exponent overflowed; result saturates to infinity of the result sign
               flags_reg[F_UNDF] <= r_unf;
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         done_reg <= 1'b0;
      end else if (CE) begin
         done_reg <= LINK.req;
      end
   end

   assign ACC = acc_reg;
   assign FLAGS = flags_reg;
   assign DONE = done_reg;
   assign LINK.ack = done_reg;
   assign LINK.acc = acc_reg;
   assign LINK.flags = flags_reg;
endmodule : brsu_unit

// [verif/brsu_sva.sv]
// concurrent checks on the link between the operand fetch end and the subtract unit
`timescale 1ns/10ps
module brsu_sva
   import brsu_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic req,
   input wire brsu_op_t op,
   input wire logic [HALF_W-1:0] lo,
   input wire logic [HALF_W-1:0] hi,
   input wire logic ptr_bad,
   input wire logic ack,
   input wire logic [ACC_W-1:0] acc,
   input wire logic [FLAG_W-1:0] flags
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic bcd_ok(input logic [ACC_W-1:0] v);
      for (int i = 0; i < NDIG; i++) begin
         if (v[i*DIG_W +: DIG_W] > BCD_MAX) return 1'b0;
      end
      return 1'b1;
   endfunction : bcd_ok
   wire logic [ACC_W-1:0] opnd = {hi, lo};
   wire logic dsub = req && op == OP_DSUB && !ptr_bad;
   wire logic rsub = req && op == OP_RSUB && !ptr_bad;
   // packed bcd orders like plain binary, so borrow is a plain compare
   wire logic dok = bcd_ok(acc) && bcd_ok(opnd);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // ------------------------------------------------------------
   // link timing
   // ------------------------------------------------------------
   property p_ack_next; req |=> ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   property p_ack_cause; ack |-> $past(req); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_hold; !ack |-> $stable(acc) && $stable(flags); endproperty
   a_hold: assert property (p_hold) else $error("state moved without an operation");
   // ------------------------------------------------------------
   // decimal subtract, and bad pointer on either subtract
   // ------------------------------------------------------------
   property p_zero; dsub && dok |=> flags[F_ZERO] == (acc == 32'h0); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_sbor; dsub && dok |=> flags[F_SBOR] == ($past(acc[15:0]) < $past(opnd[15:0])); endproperty
   a_sbor: assert property (p_sbor) else $error("short borrow wrong");
   property p_lbor;
      dsub && dok |=> flags[F_LBOR] == ($past(acc) < $past(opnd)) && flags[F_NEG] == flags[F_LBOR];
   endproperty
   a_lbor: assert property (p_lbor) else $error("long borrow or negative wrong");
   property p_dtype; dsub && !dok |=> flags[F_TYPE] && $stable(acc); endproperty
   a_dtype: assert property (p_dtype) else $error("non-decimal operand not refused");
   property p_bptr; req && op != OP_LOAD && ptr_bad |=> flags[F_BPTR] && $stable(acc); endproperty
   a_bptr: assert property (p_bptr) else $error("bad pointer not flagged");
   // ------------------------------------------------------------
   // real subtract
   // ------------------------------------------------------------
   property p_accnan;
      rsub && acc[30:23] == EXP_MAX && acc[22:0] != 23'h0 |=> flags[F_INVF] && flags[F_TYPE];
   endproperty
   a_accnan: assert property (p_accnan) else $error("nan accumulator not flagged");
   property p_rtype; rsub && opnd[30:23] == EXP_MAX |=> flags[F_TYPE] && $stable(acc); endproperty
   a_rtype: assert property (p_rtype) else $error("non-real operand not refused");
   property p_rzero;
      rsub && acc == opnd && acc[30:23] != EXP_MAX && acc[30:23] != 8'h00 |=> acc == 32'h0 && flags[F_ZERO];
   endproperty
   a_rzero: assert property (p_rzero) else $error("equal reals not giving zero");
endmodule : brsu_sva

// [verif/tb_bcd_and_real_subtract_unit.sv]
// self-checking bench: fetch end and subtract unit joined over the link
`timescale 1ns/10ps
module tb_bcd_and_real_subtract_unit
   import brsu_pkg::*;
;
   typedef struct {logic [1:0] op; logic [31:0] a, b, r; logic [8:0] f, m;} brsu_row_t;
   // small memory so the pointer range edge is cheap to reach
   localparam int DEPTH = 16;
   logic clk, rst, ce, wr_en, rd_en, irq, done;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, acc;
   logic [8:0] flags;
   int failures = 0;
   int cmp_count = 0;
   brsu_row_t rows [12] = '{
      '{OP_DSUB, 32'h00001234, 32'h00000234, 32'h00001000, 9'h000, 9'h11f},
      '{OP_DSUB, 32'h12345678, 32'h12345678, 32'h00000000, 9'h001, 9'h11f},
      '{OP_DSUB, 32'h00010000, 32'h00000001, 32'h00009999, 9'h002, 9'h11f},
      '{OP_DSUB, 32'h00000001, 32'h00000002, 32'h99999999, 9'h00e, 9'h11f},
      '{OP_DSUB, 32'h00000000, 32'h99999999, 32'h00000001, 9'h00e, 9'h11f},
      '{OP_DSUB, 32'h0000000a, 32'h00000001, 32'h0000000a, 9'h100, 9'h100},
      '{OP_RSUB, 32'h40400000, 32'h3f800000, 32'h40000000, 9'h000, 9'h1f9},
      '{OP_RSUB, 32'h3f800000, 32'h40400000, 32'hc0000000, 9'h008, 9'h1f9},
      '{OP_RSUB, 32'h3fc00000, 32'h3fc00000, 32'h00000000, 9'h001, 9'h1f9},
      '{OP_RSUB, 32'h00c00000, 32'h00800000, 32'h00000000, 9'h080, 9'h080},
      '{OP_RSUB, 32'h7f7fffff, 32'hff7fffff, 32'h7f800000, 9'h060, 9'h160},
      '{OP_RSUB, 32'h3f800000, 32'h7fc00000, 32'h3f800000, 9'h100, 9'h100}};
   brsu_if brsu_if_inst();
   brsu_fetch #(.MEM_DEPTH(DEPTH)) brsu_fetch_inst (.CLK(clk), .RST(rst), .CE(ce), .WR(wr_en), .RD(rd_en),
      .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .IRQ(irq), .LINK(brsu_if_inst));
   brsu_unit brsu_unit_inst (.CLK(clk), .RST(rst), .CE(ce), .LINK(brsu_if_inst), .ACC(acc), .FLAGS(flags),
      .DONE(done));
   brsu_sva brsu_sva_inst (.CLK(clk), .RST(rst), .req(brsu_if_inst.req), .op(brsu_if_inst.op),
      .lo(brsu_if_inst.lo), .hi(brsu_if_inst.hi), .ptr_bad(brsu_if_inst.ptr_bad), .ack(brsu_if_inst.ack),
      .acc(brsu_if_inst.acc), .flags(brsu_if_inst.flags));
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // one idle edge before each strobe, so no strobe is set twice in a step
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, e);
   endtask : reg_rd
   task automatic op_run(input logic [3:0] cmd, input logic [31:0] v);
      int n;
      n = 0;
      reg_wr(REG_IMM, v);
      reg_wr(REG_CMD, {28'h0, cmd});
      do begin
         @(posedge clk);
         #1 n++;
      end while (done !== 1'b1 && n < 8);
      chk({31'h0, done}, 32'h1);
   endtask : op_run
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      test_done;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1 chk(acc, 32'h0);
      chk({23'h0, flags}, 32'h0);
      // cmd nibble: bit3 pointer, bit2 constant, bits1:0 operation
      foreach (rows[i]) begin
         op_run(4'h4, rows[i].a);
         op_run({2'b01, rows[i].op}, rows[i].b);
         chk(acc, rows[i].r);
         chk({23'h0, flags & rows[i].m}, {23'h0, rows[i].f});
      end
      // operand from the last legal word pair, low word first
      reg_wr(REG_MADDR, 32'(DEPTH - 2));
      reg_wr(REG_MDATA, 32'h0034);
      reg_wr(REG_MADDR, 32'(DEPTH - 1));
      reg_wr(REG_MDATA, 32'h0012);
      reg_wr(REG_MADDR, 32'(DEPTH - 2));
      op_run(4'h4, 32'h00120035);
      op_run(4'h1, 32'h0);
      chk(acc, 32'h1);
      reg_wr(REG_MADDR, 32'h0);
      reg_wr(REG_MDATA, 32'(DEPTH - 2));
      op_run(4'h4, 32'h00120034);
      op_run(4'h9, 32'h0);
      chk({23'h0, flags & 9'h011}, 32'h1);
      reg_wr(REG_MDATA, 32'(DEPTH - 1));
      op_run(4'h4, 32'h77);
      op_run(4'h9, 32'h0);
      chk(acc, 32'h77);
      // zero held, bad pointer new, sign error held from the overflow row
      reg_rd(REG_FLAGS, 32'h00000051);
      chk({31'h0, flags[F_BPTR]}, 32'h1);
      op_run(4'h5, 32'h1);
      chk({31'h0, flags[F_BPTR]}, 32'h0);
      reg_rd(REG_ACC, 32'h76);
      reg_rd(8'h40, 32'h0);
      // nan accumulator on a real subtract
      op_run(4'h4, 32'h7fc00000);
      op_run(4'h6, 32'h3f800000);
      chk({23'h0, flags & 9'h120}, 32'h120);
      // interrupt: done enabled, then error alone, then masked
      reg_wr(REG_IRQ_CLR, 32'h3);
      reg_wr(REG_IRQ_EN, 32'h1);
      op_run(4'h4, 32'h5);
      settle;
      chk({31'h0, irq}, 32'h1);
      // the load still sees the held type flag of the nan case, so error is set too
      reg_rd(REG_IRQ_ST, 32'h3);
      reg_wr(REG_IRQ_CLR, 32'h3);
      settle;
      chk({31'h0, irq}, 32'h0);
      reg_wr(REG_IRQ_EN, 32'h2);
      op_run(4'h5, 32'h0000000b);
      settle;
      chk({31'h0, irq}, 32'h1);
      reg_rd(REG_IRQ_ST, 32'h3);
      reg_wr(REG_IRQ_EN, 32'h0);
      settle;
      chk({31'h0, irq}, 32'h0);
      // clock enable low: a load command is not taken, nothing moves
      @(posedge clk);
      ce <= 1'b0;
      reg_wr(REG_CMD, 32'h4);
      settle;
      chk(acc, 32'h5);
      chk({31'h0, done}, 32'h0);
      @(posedge clk);
      ce <= 1'b1;
      reg_rd(REG_STAT, 32'h0);
      // reset in mid-run clears every register; the word memory has no reset
      @(posedge clk);
      rst <= 1'b1;
      settle;
      chk(acc, 32'h0);
      chk({22'h0, flags, irq}, 32'h0);
      @(posedge clk);
      rst <= 1'b0;
      op_run(4'h4, 32'h9);
      op_run(4'h5, 32'h9);
      chk({23'h0, flags & 9'h10f}, 32'h1);
      test_done;
   end
endmodule : tb_bcd_and_real_subtract_unit
